// File: pke_pkg.sv
// Shared constants and types of the public-key configuration and operand store
package pke_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int unsigned IDX_W = 15;
	localparam logic [14:0] IDX_FORM = 15'h2050;
	localparam logic [14:0] IDX_EXPCFG = 15'h2051;
	localparam logic [14:0] IDX_CFG_RSV2 = 15'h2052;
	localparam logic [14:0] IDX_CFG_RSV3 = 15'h2053;
	localparam logic [14:0] IDX_REV = 15'h2080;
	localparam logic [14:0] IDX_ID_RSV1 = 15'h2081;
	localparam logic [14:0] IDX_PROJ_LO = 15'h2082;
	localparam logic [14:0] IDX_PROJ_HI = 15'h2083;
	localparam logic [14:0] IDX_BANK_A_FIRST = 15'h2400;
	localparam logic [14:0] IDX_BANK_A_LAST = 15'h2E10;
	localparam logic [14:0] IDX_BANK_B_FIRST = 15'h3000;
	localparam logic [14:0] IDX_BANK_B_LAST = 15'h4A10;

	// ----------------------------------------------------------------
	// Operand bank geometry
	// ----------------------------------------------------------------
	localparam int unsigned BANK_A_AW = 12;
	localparam int unsigned BANK_B_AW = 13;
	localparam int unsigned BANK_A_DEPTH =
		int'(IDX_BANK_A_LAST - IDX_BANK_A_FIRST) + 1;
	localparam int unsigned BANK_B_DEPTH =
		int'(IDX_BANK_B_LAST - IDX_BANK_B_FIRST) + 1;
	localparam logic [14:0] EXP_WORD_OFS = 15'h0001;

	// ----------------------------------------------------------------
	// Field positions, masks and reset values
	// ----------------------------------------------------------------
	localparam int unsigned FORM_OP0_IMON_BIT = 1;
	localparam int unsigned FORM_OUTPUT_AFFINE_SELECT_BIT = 4;
	localparam int unsigned FORM_OUTPUT_MONTGOMERY_SELECT_BIT = 5;
	localparam logic [7:0] FORM_RST = 8'h2A;
	localparam logic [7:0] FORM_MASK = 8'h32;
	localparam logic [7:0] EXPCFG_RST = 8'h00;
	localparam logic [7:0] EXPCFG_MASK = 8'h03;
	localparam int unsigned REV_MINOR_LSB = 0;
	localparam int unsigned REV_MAJOR_LSB = 4;

	// ----------------------------------------------------------------
	// Identification values (arbitrary neutral values)
	// ----------------------------------------------------------------
	localparam logic [3:0] MINOR_REV = 4'h1;
	localparam logic [3:0] MAJOR_REV = 4'h2;
	localparam logic [15:0] PROJECT_ID = 16'h5A3C;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PKE_EXP_SEC_PUBPRIV = 2'b00,
		PKE_EXP_SEC_PRIV = 2'b01,
		PKE_EXP_LADDER = 2'b10,
		PKE_EXP_PLAIN_PUB = 2'b11
	} pke_exp_alg_t;

	typedef enum logic [1:0] {
		PKE_OP_OTHER = 2'b00,
		PKE_OP_ECC = 2'b01,
		PKE_OP_RSA_MODEXP = 2'b10,
		PKE_OP_MODMUL = 2'b11
	} pke_op_kind_t;

	typedef enum logic [1:0] {
		PKE_BUS_IDLE = 2'b00,
		PKE_BUS_FETCH = 2'b01,
		PKE_BUS_ANSWER = 2'b10
	} pke_bus_state_t;

endpackage

// File: pke_opbank.sv
// Single-port word store with byte enables and registered read data
module pke_opbank #(
	parameter int unsigned AW = 12,
	parameter int unsigned DEPTH = 4096
) (
	// Clock
	input wire logic clk_i,
	// Access port
	input wire logic we_i,
	input wire logic [3:0] be_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic [31:0] rdata_o
);

	logic [31:0] mem [DEPTH];
	logic [31:0] rdata_q;

	// ----------------------------------------------------------------
	// Storage; contents undefined after reset on purpose
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		for (int b = 0; b < 4; b++) begin
			if (we_i && be_i[b]) begin
				mem[addr_i][8*b +: 8] <= wdata_i[8*b +: 8];
			end
		end
		rdata_q <= mem[addr_i];
	end

	assign rdata_o = rdata_q;

endmodule

// File: pke_cfg_store.sv
// Output-form and exponent configuration with operand banks, Wishbone slave
//
// Behaviour
// - affine bit picks affine else Jacobian output
// - affine choice used only for elliptic operations
// - Montgomery bit picks Montgomery else normal results
// - algorithm selector only affects RSA exponentiation
// - 00 protected, both keys, exponent B word1
// - 01 protected, private key, exponent B word1
// - 10 runs Montgomery ladder exponentiation
// - 11 unprotected, public key, exponent A word1
// - revision byte holds minor and major versions
// - project number read-only in bits 7:0 of words 0x2082 (low byte) and 0x2083 (high byte)
// - bank A read-write words 0x2400 to 0x2E10
// - bank B read-write words 0x3000 to 0x4A10
// - operand0 clear Montgomery bit means convert first, except for PKE_OP_OTHER operations
module pke_cfg_store (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Engine operation request
	input wire logic op_valid_i,
	input wire pke_pkg::pke_op_kind_t op_kind_i,
	// Engine form and algorithm controls
	output logic output_affine_o,
	output logic output_montgomery_o,
	output logic operand0_convert_o,
	output logic exp_alg_valid_o,
	output pke_pkg::pke_exp_alg_t exp_algorithm_select_o,
	output logic exp_from_first_bank_o,
	output logic exp_needs_public_o,
	output logic exp_needs_private_o,
	output logic [31:0] exponent_o
);
	import pke_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pke_bus_state_t state_q, state_d;
	logic ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [7:0] form_q, form_d;
	logic [7:0] expcfg_q, expcfg_d;
	logic [31:0] bank_first_word1_q, bank_first_word1_d;
	logic [31:0] bank_second_word1_q, bank_second_word1_d;
	logic [14:0] idx_q, idx_d;
	logic hit_a_q, hit_a_d;
	logic hit_b_q, hit_b_d;

	logic output_affine_select_q, output_affine_select_d;
	logic output_montgomery_select_q, output_montgomery_select_d;
	logic conv_q, conv_d;
	logic alg_valid_q, alg_valid_d;
	pke_exp_alg_t alg_q, alg_d;
	logic from_first_q, from_first_d;
	logic need_pub_q, need_pub_d;
	logic need_priv_q, need_priv_d;
	logic [31:0] exp_q, exp_d;

	logic [14:0] idx;
	logic in_range;
	logic req;
	logic sel_a, sel_b;
	logic [BANK_A_AW-1:0] addr_a;
	logic [BANK_B_AW-1:0] addr_b;
	logic wr_a, wr_b;
	logic [31:0] rdata_a, rdata_b;
	logic [31:0] reg_rdata;
	logic [31:0] byte_mask;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Word index; upper address bits must be zero for any hit
	assign idx = adr_i[16:2];
	assign in_range = (adr_i[31:17] == 15'h0000);
	// Writes land on the edge where the master sees ack, never before
	assign req = cyc_i && stb_i && (state_q == PKE_BUS_ANSWER);

	assign sel_a = in_range && (idx >= IDX_BANK_A_FIRST)
		&& (idx <= IDX_BANK_A_LAST);
	assign sel_b = in_range && (idx >= IDX_BANK_B_FIRST)
		&& (idx <= IDX_BANK_B_LAST);

	assign addr_a = BANK_A_AW'(idx - IDX_BANK_A_FIRST);
	assign addr_b = BANK_B_AW'(idx - IDX_BANK_B_FIRST);
	assign wr_a = req && we_i && sel_a;
	assign wr_b = req && we_i && sel_b;

	always_comb begin
		byte_mask = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			byte_mask[8*b +: 8] = {8{sel_i[b]}};
		end
	end

	// ----------------------------------------------------------------
	// Operand banks
	// ----------------------------------------------------------------
	pke_opbank #(
		.AW(BANK_A_AW),
		.DEPTH(BANK_A_DEPTH)
	) u_bank_first (
		.clk_i(clk_i),
		.we_i(wr_a),
		.be_i(sel_i),
		.addr_i(addr_a),
		.wdata_i(dat_i),
		.rdata_o(rdata_a)
	);

	pke_opbank #(
		.AW(BANK_B_AW),
		.DEPTH(BANK_B_DEPTH)
	) u_bank_second (
		.clk_i(clk_i),
		.we_i(wr_b),
		.be_i(sel_i),
		.addr_i(addr_b),
		.wdata_i(dat_i),
		.rdata_o(rdata_b)
	);

	// ----------------------------------------------------------------
	// Register read mux (uses index latched at request)
	// ----------------------------------------------------------------
	always_comb begin
		reg_rdata = 32'h00000000;
		case (idx_q)
			IDX_FORM: begin
				reg_rdata = {24'h000000, form_q & FORM_MASK};
			end
			IDX_EXPCFG: begin
				reg_rdata = {24'h000000, expcfg_q & EXPCFG_MASK};
			end
			IDX_REV: begin
				reg_rdata = {24'h000000, MAJOR_REV, MINOR_REV};
			end
			IDX_PROJ_LO: begin
				reg_rdata = {24'h000000, PROJECT_ID[7:0]};
			end
			IDX_PROJ_HI: begin
				reg_rdata = {24'h000000, PROJECT_ID[15:8]};
			end
			// Reserved bytes and unmapped words answer zero
			default: begin
				reg_rdata = 32'h00000000;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Bus sequencer: request, fetch, answer
	// ----------------------------------------------------------------
	// Two-cycle answer keeps dat_o a plain flop behind registered RAM
	always_comb begin
		state_d = state_q;
		ack_d = 1'b0;
		dat_d = dat_q;
		idx_d = idx_q;
		hit_a_d = hit_a_q;
		hit_b_d = hit_b_q;
		case (state_q)
			PKE_BUS_IDLE: begin
				if (cyc_i && stb_i) begin
					idx_d = in_range ? idx : 15'h7FFF;
					hit_a_d = sel_a;
					hit_b_d = sel_b;
					state_d = PKE_BUS_FETCH;
				end
			end
			PKE_BUS_FETCH: begin
				if (hit_a_q) begin
					dat_d = rdata_a;
				end else if (hit_b_q) begin
					dat_d = rdata_b;
				end else begin
					dat_d = reg_rdata;
				end
				ack_d = 1'b1;
				state_d = PKE_BUS_ANSWER;
			end
			PKE_BUS_ANSWER: begin
				state_d = PKE_BUS_IDLE;
			end
			default: begin
				state_d = PKE_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= PKE_BUS_IDLE;
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
			idx_q <= 15'h0000;
			hit_a_q <= 1'b0;
			hit_b_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
			idx_q <= idx_d;
			hit_a_q <= hit_a_d;
			hit_b_q <= hit_b_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ----------------------------------------------------------------
	// Configuration registers and exponent word shadows
	// ----------------------------------------------------------------
	// Shadows let the engine read word 1 of each bank without a port
	always_comb begin
		form_d = form_q;
		expcfg_d = expcfg_q;
		bank_first_word1_d = bank_first_word1_q;
		bank_second_word1_d = bank_second_word1_q;
		if (req && we_i && in_range && sel_i[0]) begin
			if (idx == IDX_FORM) begin
				form_d = dat_i[7:0] & FORM_MASK;
			end
			if (idx == IDX_EXPCFG) begin
				expcfg_d = dat_i[7:0] & EXPCFG_MASK;
			end
		end
		if (wr_a && idx == IDX_BANK_A_FIRST + EXP_WORD_OFS) begin
			bank_first_word1_d = (bank_first_word1_q & ~byte_mask)
				| (dat_i & byte_mask);
		end
		if (wr_b && idx == IDX_BANK_B_FIRST + EXP_WORD_OFS) begin
			bank_second_word1_d = (bank_second_word1_q & ~byte_mask)
				| (dat_i & byte_mask);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			form_q <= FORM_RST & FORM_MASK;
			expcfg_q <= EXPCFG_RST & EXPCFG_MASK;
		end else begin
			form_q <= form_d;
			expcfg_q <= expcfg_d;
		end
		// No reset: shadows must agree with banks, which keep data
		bank_first_word1_q <= bank_first_word1_d;
		bank_second_word1_q <= bank_second_word1_d;
	end

	// ----------------------------------------------------------------
	// Engine controls, latched when an operation starts
	// ----------------------------------------------------------------
	// Held stable for the whole operation even if software rewrites
	always_comb begin
		output_affine_select_d = output_affine_select_q;
		output_montgomery_select_d = output_montgomery_select_q;
		conv_d = conv_q;
		alg_valid_d = alg_valid_q;
		alg_d = alg_q;
		from_first_d = from_first_q;
		need_pub_d = need_pub_q;
		need_priv_d = need_priv_q;
		exp_d = exp_q;
		if (op_valid_i) begin
			output_affine_select_d = form_q[FORM_OUTPUT_AFFINE_SELECT_BIT]
				&& (op_kind_i == PKE_OP_ECC);
			output_montgomery_select_d = form_q[FORM_OUTPUT_MONTGOMERY_SELECT_BIT];
			conv_d = !form_q[FORM_OP0_IMON_BIT]
				&& (op_kind_i != PKE_OP_OTHER);
			alg_valid_d = (op_kind_i == PKE_OP_RSA_MODEXP);
			alg_d = pke_exp_alg_t'(expcfg_q[1:0]);
			from_first_d = 1'b0;
			need_pub_d = 1'b0;
			need_priv_d = 1'b0;
			exp_d = 32'h00000000;
			if (op_kind_i == PKE_OP_RSA_MODEXP) begin
				case (pke_exp_alg_t'(expcfg_q[1:0]))
					PKE_EXP_SEC_PUBPRIV: begin
						need_pub_d = 1'b1;
						need_priv_d = 1'b1;
						exp_d = bank_second_word1_q;
					end
					PKE_EXP_SEC_PRIV: begin
						need_priv_d = 1'b1;
						exp_d = bank_second_word1_q;
					end
					PKE_EXP_LADDER: begin
						need_priv_d = 1'b1;
						exp_d = bank_second_word1_q;
					end
					PKE_EXP_PLAIN_PUB: begin
						need_pub_d = 1'b1;
						from_first_d = 1'b1;
						exp_d = bank_first_word1_q;
					end
					default: begin
						exp_d = 32'h00000000;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			output_affine_select_q <= 1'b0;
			output_montgomery_select_q <= 1'b0;
			conv_q <= 1'b0;
			alg_valid_q <= 1'b0;
			alg_q <= PKE_EXP_SEC_PUBPRIV;
			from_first_q <= 1'b0;
			need_pub_q <= 1'b0;
			need_priv_q <= 1'b0;
			exp_q <= 32'h00000000;
		end else begin
			output_affine_select_q <= output_affine_select_d;
			output_montgomery_select_q <= output_montgomery_select_d;
			conv_q <= conv_d;
			alg_valid_q <= alg_valid_d;
			alg_q <= alg_d;
			from_first_q <= from_first_d;
			need_pub_q <= need_pub_d;
			need_priv_q <= need_priv_d;
			exp_q <= exp_d;
		end
	end

	assign output_affine_o = output_affine_select_q;
	assign output_montgomery_o = output_montgomery_select_q;
	assign operand0_convert_o = conv_q;
	assign exp_alg_valid_o = alg_valid_q;
	assign exp_algorithm_select_o = alg_q;
	assign exp_from_first_bank_o = from_first_q;
	assign exp_needs_public_o = need_pub_q;
	assign exp_needs_private_o = need_priv_q;
	assign exponent_o = exp_q;

endmodule

// File: pke_cfg_store_checker.sv
// Port-level assertions for the configuration store
module pke_cfg_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Engine
	input wire logic op_valid_i,
	input wire pke_pkg::pke_op_kind_t op_kind_i,
	input wire logic output_affine_o,
	input wire logic exp_alg_valid_o,
	input wire pke_pkg::pke_exp_alg_t exp_algorithm_select_o,
	input wire logic exp_from_first_bank_o,
	input wire logic exp_needs_public_o,
	input wire logic exp_needs_private_o,
	input wire logic [31:0] exponent_o
);
	import pke_pkg::*;
	logic rd;
	logic [2:0] keys;
	assign rd = ack_o && !we_i;
	assign keys = {exp_from_first_bank_o, exp_needs_public_o,
		exp_needs_private_o};
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------------------------
	// Bus timing and read values
	// ------------------------------------------------
	property p_lat;
		$rose(cyc_i && stb_i) |-> !ack_o ##1 !ack_o ##1 ack_o ##1 !ack_o;
	endproperty
	a_lat: assert property (p_lat) else $error("ack timing");
	property p_rev;
		rd && adr_i == 32'h8200 |-> dat_o == {24'h0, MAJOR_REV, MINOR_REV};
	endproperty
	a_rev: assert property (p_rev) else $error("revision");
	property p_unm;
		rd && adr_i[31:17] != 15'h0 |-> dat_o == 32'h0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	// ------------------------------------------------
	// Engine controls
	// ------------------------------------------------
	property p_aff;
		op_valid_i && op_kind_i != PKE_OP_ECC |=> !output_affine_o;
	endproperty
	a_aff: assert property (p_aff) else $error("affine leak");
	property p_nrsa;
		op_valid_i && op_kind_i != PKE_OP_RSA_MODEXP |=> !exp_alg_valid_o
			&& exponent_o == 32'h0 && keys == 3'b000;
	endproperty
	a_nrsa: assert property (p_nrsa) else $error("alg leak");
	property p_hold;
		!op_valid_i |=> $stable(exponent_o) && $stable(keys);
	endproperty
	a_hold: assert property (p_hold) else $error("not held");
	property p_s0;
		exp_alg_valid_o && exp_algorithm_select_o == PKE_EXP_SEC_PUBPRIV
			|-> keys == 3'b011;
	endproperty
	a_s0: assert property (p_s0) else $error("sel 00");
	property p_s1;
		exp_alg_valid_o && exp_algorithm_select_o == PKE_EXP_SEC_PRIV
			|-> keys == 3'b001;
	endproperty
	a_s1: assert property (p_s1) else $error("sel 01");
	property p_s2;
		exp_alg_valid_o && exp_algorithm_select_o == PKE_EXP_LADDER
			|-> !exp_from_first_bank_o;
	endproperty
	a_s2: assert property (p_s2) else $error("sel 10");
	property p_s3;
		exp_alg_valid_o && exp_algorithm_select_o == PKE_EXP_PLAIN_PUB
			|-> keys == 3'b110;
	endproperty
	a_s3: assert property (p_s3) else $error("sel 11");
	c_rd: cover property (rd);
	c_rsa: cover property (op_valid_i && op_kind_i == PKE_OP_RSA_MODEXP);
	c_ecc: cover property (op_valid_i && op_kind_i == PKE_OP_ECC);
endmodule

bind pke_cfg_store pke_cfg_chk u_chk (
	.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
	.op_valid_i, .op_kind_i, .output_affine_o, .exp_alg_valid_o,
	.exp_algorithm_select_o, .exp_from_first_bank_o, .exp_needs_public_o,
	.exp_needs_private_o, .exponent_o
);

// File: testbench.sv
// Self-checking bench for the configuration store
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pke_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic op_valid_i = 1'b0;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] adr_i = 32'h0;
	logic [31:0] dat_i = 32'h0;
	pke_op_kind_t op_kind_i = PKE_OP_OTHER;
	logic [31:0] dat_o, exponent_o, r;
	logic ack_o, output_affine_o, output_montgomery_o, operand0_convert_o;
	logic exp_alg_valid_o, exp_from_first_bank_o;
	logic exp_needs_public_o, exp_needs_private_o;
	pke_exp_alg_t exp_algorithm_select_o;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	integer seed = 32'hc7c796b2;
	logic [31:0] rd_q[$];
	logic [40:0] eng_q[$];
	logic [7:0] form_m = 8'h22;
	logic [1:0] alg_m = 2'b00;
	logic [31:0] a1, b1;
	logic pend = 1'b0;
	logic [31:0] bank[6] = '{32'h9000, 32'h9004, 32'hB840, 32'hC000,
		32'hC004, 32'h12840};

	pke_cfg_store DUT (
		.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .op_valid_i, .op_kind_i, .output_affine_o,
		.output_montgomery_o, .operand0_convert_o, .exp_alg_valid_o,
		.exp_algorithm_select_o, .exp_from_first_bank_o,
		.exp_needs_public_o, .exp_needs_private_o, .exponent_o
	);

	initial forever #10 clk_i = ~clk_i;

	task automatic final_report();
		$display("checks %0d bad %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cmp_rd(input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t read %h want %h", $time, g, e);
		end
	endtask

	task automatic cmp_eng(input logic [40:0] e, g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %0t engine %h want %h", $time, g, e);
		end
	endtask

	// ------------------------------------------------
	// Bus master: holds the request until ack is seen
	// ------------------------------------------------
	task automatic wb(input logic w, input logic [31:0] a, d,
		input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [31:0] a, d, input logic [3:0] s = 4'hF);
		wb(1'b1, a, d, s);
	endtask

	task automatic rd(input logic [31:0] a, e, input logic w = 1'b0);
		if (w) wr(a, $random(seed));
		rd_q.push_back(e);
		wb(1'b0, a, $random(seed), 4'hF);
	endtask

	// Read-only places get a stray write first when w is set
	task automatic regs(input logic w);
		rd(32'h8140, {24'h0, form_m});
		rd(32'h8144, {30'h0, alg_m});
		rd(32'h8148, 32'h0, w);
		rd(32'h814C, 32'h0, w);
		rd(32'h8200, {24'h0, MAJOR_REV, MINOR_REV}, w);
		rd(32'h8204, 32'h0, w);
		rd(32'h8208, {24'h0, PROJECT_ID[7:0]}, w);
		rd(32'h820C, {24'h0, PROJECT_ID[15:8]}, w);
	endtask

	function automatic logic [40:0] eng_exp(pke_op_kind_t k);
		logic q;
		logic [1:0] s;
		q = (k == PKE_OP_RSA_MODEXP);
		s = q ? alg_m : 2'b00;
		return {form_m[4] && k == PKE_OP_ECC, form_m[5],
			!form_m[1] && k != PKE_OP_OTHER, q, s, q && s == 2'b11,
			q && s[1] == s[0], q && s != 2'b11,
			!q ? 32'h0 : s == 2'b11 ? a1 : b1};
	endfunction

	// Caller lowers the request after the last of a back-to-back run
	task automatic op(input pke_op_kind_t k);
		eng_q.push_back(eng_exp(k));
		op_valid_i <= 1'b1;
		op_kind_i <= k;
		@(posedge clk_i);
	endtask

	always @(posedge clk_i) begin
		pend <= op_valid_i;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			final_report();
		end
	end

	always @(negedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0)
			cmp_rd(rd_q.pop_front(), dat_o);
		if (pend)
			cmp_eng(eng_q.pop_front(), {output_affine_o, output_montgomery_o,
				operand0_convert_o, exp_alg_valid_o,
				exp_algorithm_select_o & {2{exp_alg_valid_o}},
				exp_from_first_bank_o, exp_needs_public_o,
				exp_needs_private_o, exponent_o});
	end

	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		regs(1'b1);
		wr(32'h8140, 32'hFFFFFFFF, 4'hE);
		rd(32'h8140, 32'h22);
		foreach (bank[i]) begin
			r = $random(seed);
			wr(bank[i], r);
			rd(bank[i], r);
			if (i == 1) a1 = r;
			if (i == 4) b1 = r;
		end
		wr(32'h9008, 32'hFFFFFFFF);
		wr(32'h9008, 32'h0, 4'b0101);
		rd(32'h9008, 32'hFF00FF00);
		rd(32'h00020000, 32'h0, 1'b1);
		rd(32'hB844, 32'h0, 1'b1);
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			r[1:0] = i[1:0];
			alg_m = i[1:0];
			wr(32'h8144, r);
			rd(32'h8144, {30'h0, alg_m});
			op(PKE_OP_RSA_MODEXP);
			op_valid_i <= 1'b0;
		end
		for (int j = 0; j < 4; j++) begin
			r = $random(seed);
			r[5:4] = j[1:0];
			r[1] = j[0] ^ j[1];
			form_m = r[7:0] & 8'h32;
			wr(32'h8140, r);
			for (int k = 0; k < 4; k++)
				op(pke_op_kind_t'(k));
			op_valid_i <= 1'b0;
		end
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		form_m = 8'h22;
		alg_m = 2'b00;
		regs(1'b0);
		op(PKE_OP_MODMUL);
		op_valid_i <= 1'b0;
		// Software picks: protected private-key, then plain public
		for (int i = 1; i < 4; i += 2) begin
			alg_m = i[1:0];
			wr(32'h8144, i);
			op(PKE_OP_RSA_MODEXP);
			op_valid_i <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		final_report();
	end
endmodule
